// ---- rtl/utr_pkg.sv ----
// Summary of operation
// - tx select 0: irq on every buffer-to-shifter move
// - tx select 1: irq when move empties buffer
// - tx flag edge-set; select switchable while running
// - break bit forces transmit line low
// - break never raises the transmit interrupt
// - four-word receive buffer plus shift register
// - data available set while buffer non-empty
// - empty read returns stale data, no advance
// - read advances fifo, updates parity/framing flags
// - fifo cleared by reset, kept across power-save
// - rx flag edge-set, condition from select field
// - select 00/01: irq on every transfer
// - select 10: irq when buffer reaches three
// - select 11: irq when buffer becomes full
// - overrun when new character completes while full buffer blocks held word
package utr_pkg;
  // ------------------------------------------------------------
  // sizes and timing
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int RX_DEPTH = 4;
  localparam int TX_DEPTH = 4;
  localparam int OVERSAMPLE = 16;
  localparam int SAMPLE_POINT = 7;
  localparam int RX_LEVEL_THREE = 3;
  // ------------------------------------------------------------
  // status word bit positions
  // ------------------------------------------------------------
  localparam int STAT_W = 16;
  localparam int STAT_RX_AVAIL = 0;
  localparam int STAT_OVERRUN = 1;
  localparam int STAT_FRAMING = 2;
  localparam int STAT_PARITY = 3;
  localparam int STAT_RX_SEL_LO = 6;
  localparam int STAT_TX_IDLE = 8;
  localparam int STAT_TX_FULL = 9;
  localparam int STAT_TX_BREAK = 11;
  localparam int STAT_TX_SEL = 15;
  // ------------------------------------------------------------
  // encodings and reset values
  // ------------------------------------------------------------
  localparam logic [1:0] RXSEL_EACH_A = 2'h0;
  localparam logic [1:0] RXSEL_EACH_B = 2'h1;
  localparam logic [1:0] RXSEL_THREE = 2'h2;
  localparam logic [1:0] RXSEL_FULL = 2'h3;
  localparam logic TXSEL_SLOT_FREE = 1'h0;
  localparam logic TXSEL_EMPTY = 1'h1;
  localparam logic LINE_IDLE = 1'h1;
  localparam logic LINE_BREAK = 1'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [STAT_W-1:0] STAT_RST = 16'h0000;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} utr_rx_state_type;
endpackage : utr_pkg

// ---- rtl/utr_tx_shift.sv ----
`timescale 1ns/10ps
module utr_tx_shift #(
  parameter int DATA_W = utr_pkg::DATA_W,
  parameter int OVERSAMPLE = utr_pkg::OVERSAMPLE
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic baud_tick,
  input wire logic load,
  input wire logic [DATA_W-1:0] load_data,
  input wire logic parity_en,
  input wire logic tx_break,
  output logic tx_line_q,
  output logic busy_q
);
  import utr_pkg::*;

  // ------------------------------------------------------------
  // frame: start, data lsb first, optional parity, stop
  // ------------------------------------------------------------
  localparam int FRAME_W = DATA_W + 3;
  localparam int BW = $clog2(FRAME_W + 1);
  localparam int TW = $clog2(OVERSAMPLE);
  localparam logic [BW-1:0] BITS_PAR = BW'(FRAME_W);
  localparam logic [BW-1:0] BITS_NOPAR = BW'(FRAME_W - 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(OVERSAMPLE - 1);

  if (OVERSAMPLE < 2) begin : g_bad_os
    $error("utr_tx_shift: OVERSAMPLE must be at least 2");
  end

  logic [FRAME_W-1:0] shift_q;
  logic [BW-1:0] bits_left_q;
  logic [TW-1:0] tick_q;
  logic bit_end;

  assign bit_end = busy_q && baud_tick && (tick_q == TICK_LAST);

  // ------------------------------------------------------------
  // shifter
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_q <= '1;
      bits_left_q <= '0;
      busy_q <= 1'b0;
    end else if (load && !busy_q) begin
      // without parity the parity slot is sent as the stop bit; the top stop bit is sent only with parity
      shift_q <= {1'b1, (parity_en ? ^load_data : 1'b1), load_data, 1'b0};
      bits_left_q <= parity_en ? BITS_PAR : BITS_NOPAR;
      busy_q <= 1'b1;
    end else if (bit_end) begin
      shift_q <= {1'b1, shift_q[FRAME_W-1:1]};
      bits_left_q <= bits_left_q - BW'(1);
      busy_q <= (bits_left_q != BW'(1));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_q <= '0;
    end else if (!busy_q) begin
      tick_q <= '0;
    end else if (baud_tick) begin
      tick_q <= (tick_q == TICK_LAST) ? '0 : tick_q + TW'(1);
    end
  end

  // ------------------------------------------------------------
  // line driver
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_line_q <= LINE_IDLE;
    end else if (tx_break) begin
      tx_line_q <= LINE_BREAK;
    end else begin
      tx_line_q <= busy_q ? shift_q[0] : LINE_IDLE;
    end
  end
endmodule : utr_tx_shift

// ---- rtl/utr_rx_shift.sv ----
`timescale 1ns/10ps
module utr_rx_shift #(
  parameter int DATA_W = utr_pkg::DATA_W,
  parameter int OVERSAMPLE = utr_pkg::OVERSAMPLE
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic baud_tick,
  input wire logic rx_line,
  input wire logic parity_en,
  output logic char_valid_q,
  output logic [DATA_W-1:0] char_data_q,
  output logic char_parity_error_q,
  output logic char_framing_error_q
);
  import utr_pkg::*;

  localparam int TW = $clog2(OVERSAMPLE);
  localparam int CW = $clog2(DATA_W + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(OVERSAMPLE - 1);
  localparam logic [TW-1:0] TICK_MID = TW'(SAMPLE_POINT);
  localparam logic [CW-1:0] LAST_BIT = CW'(DATA_W - 1);

  if (OVERSAMPLE < 2 * (SAMPLE_POINT + 1)) begin : g_bad_os
    $error("utr_rx_shift: OVERSAMPLE too small to sample mid-bit");
  end

  utr_rx_state_type state_q;
  logic [TW-1:0] tick_q;
  logic [CW-1:0] bit_q;
  logic [DATA_W-1:0] data_q;
  logic par_q;
  logic sample;

  assign sample = baud_tick && (tick_q == TICK_MID) && (state_q != RX_IDLE);

  // ------------------------------------------------------------
  // bit timing
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_q <= '0;
    end else if (state_q == RX_IDLE) begin
      tick_q <= '0;
    end else if (baud_tick) begin
      tick_q <= (tick_q == TICK_LAST) ? '0 : tick_q + TW'(1);
    end
  end

  // ------------------------------------------------------------
  // frame sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= RX_IDLE;
      bit_q <= '0;
      data_q <= '0;
      par_q <= 1'b0;
    end else begin
      unique case (state_q)
        RX_IDLE: begin
          if (!rx_line) begin
            state_q <= RX_START;
          end
        end
        RX_START: begin
          // a start bit that is high again at mid-bit was a glitch
          if (sample) begin
            state_q <= rx_line ? RX_IDLE : RX_DATA;
            bit_q <= '0;
          end
        end
        RX_DATA: begin
          if (sample) begin
            data_q <= {rx_line, data_q[DATA_W-1:1]};
            bit_q <= bit_q + CW'(1);
            if (bit_q == LAST_BIT) begin
              state_q <= parity_en ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (sample) begin
            par_q <= rx_line;
            state_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (sample) begin
            state_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // completed character, pulsed at the stop-bit sample
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      char_valid_q <= 1'b0;
      char_data_q <= DATA_RST;
      char_parity_error_q <= 1'b0;
      char_framing_error_q <= 1'b0;
    end else begin
      char_valid_q <= sample && (state_q == RX_STOP);
      if (sample && (state_q == RX_STOP)) begin
        char_data_q <= data_q;
        char_parity_error_q <= parity_en && (par_q != ^data_q);
        char_framing_error_q <= !rx_line;
      end
    end
  end
endmodule : utr_rx_shift

// ---- rtl/utr_uart.sv ----
`timescale 1ns/10ps
module utr_uart #(
  parameter int DATA_W = utr_pkg::DATA_W,
  parameter int RX_DEPTH = utr_pkg::RX_DEPTH,
  parameter int TX_DEPTH = utr_pkg::TX_DEPTH,
  parameter int OVERSAMPLE = utr_pkg::OVERSAMPLE
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic baud_tick,
  input wire logic parity_en,
  input wire logic tx_write,
  input wire logic [DATA_W-1:0] tx_wdata,
  input wire logic tx_irq_select,
  input wire logic tx_break,
  input wire logic tx_irq_clear,
  input wire logic rx_line,
  input wire logic rx_read,
  input wire logic [1:0] rx_irq_select,
  input wire logic rx_irq_clear,
  input wire logic overrun_clear,
  output logic tx_line,
  output logic tx_buffer_full_q,
  output logic tx_idle_q,
  output logic tx_irq_flag_q,
  output logic [DATA_W-1:0] rx_data_q,
  output logic parity_error_q,
  output logic framing_error_q,
  output logic rx_data_available_q,
  output logic overrun_error_q,
  output logic rx_irq_flag_q,
  output logic [utr_pkg::STAT_W-1:0] status_q
);
  import utr_pkg::*;

  // ------------------------------------------------------------
  // sizing
  // ------------------------------------------------------------
  localparam int RCW = $clog2(RX_DEPTH + 1);
  localparam int RPW = $clog2(RX_DEPTH);
  localparam int TCW = $clog2(TX_DEPTH + 1);
  localparam int TPW = $clog2(TX_DEPTH);
  localparam int WW = DATA_W + 2;
  localparam logic [RCW-1:0] RX_FULL = RCW'(RX_DEPTH);
  localparam logic [RCW-1:0] RX_THREE = RCW'(RX_LEVEL_THREE);
  localparam logic [RPW-1:0] RX_PTR_LAST = RPW'(RX_DEPTH - 1);
  localparam logic [TCW-1:0] TX_FULL = TCW'(TX_DEPTH);
  localparam logic [TPW-1:0] TX_PTR_LAST = TPW'(TX_DEPTH - 1);

  // the threshold mode needs a buffer at least three deep
  if (RX_DEPTH < RX_LEVEL_THREE) begin : g_bad_rx
    $error("utr_uart: RX_DEPTH must be at least 3");
  end
  if (TX_DEPTH < 2) begin : g_bad_tx
    $error("utr_uart: TX_DEPTH must be at least 2");
  end

  // ------------------------------------------------------------
  // transmit buffer
  // ------------------------------------------------------------
  logic [DATA_W-1:0] tx_mem [TX_DEPTH];
  logic [TPW-1:0] tx_wr_q;
  logic [TPW-1:0] tx_rd_q;
  logic [TCW-1:0] tx_count_q;
  logic [TCW-1:0] tx_count_d;
  logic tx_push;
  logic tx_load;
  logic tx_busy;
  logic tx_event;

  assign tx_push = tx_write && (tx_count_q != TX_FULL);
  // no load while breaking, so a break never moves a word
  assign tx_load = !tx_busy && (tx_count_q != '0) && !tx_break;

  always_comb begin
    tx_count_d = tx_count_q;
    if (tx_push && !tx_load) begin
      tx_count_d = tx_count_q + TCW'(1);
    end else if (tx_load && !tx_push) begin
      tx_count_d = tx_count_q - TCW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (tx_push) begin
      tx_mem[tx_wr_q] <= tx_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_wr_q <= '0;
      tx_rd_q <= '0;
      tx_count_q <= '0;
    end else begin
      if (tx_push) begin
        tx_wr_q <= (tx_wr_q == TX_PTR_LAST) ? '0 : tx_wr_q + TPW'(1);
      end
      if (tx_load) begin
        tx_rd_q <= (tx_rd_q == TX_PTR_LAST) ? '0 : tx_rd_q + TPW'(1);
      end
      tx_count_q <= tx_count_d;
    end
  end

  utr_tx_shift #(
    .DATA_W(DATA_W),
    .OVERSAMPLE(OVERSAMPLE)
  ) u_tx (
    .clk(clk),
    .rst(rst),
    .baud_tick(baud_tick),
    .load(tx_load),
    .load_data(tx_mem[tx_rd_q]),
    .parity_en(parity_en),
    .tx_break(tx_break),
    .tx_line_q(tx_line),
    .busy_q(tx_busy)
  );

  // ------------------------------------------------------------
  // transmit interrupt
  // ------------------------------------------------------------
  // select is read live, so software may change it at any time
  assign tx_event = tx_load && ((tx_irq_select == TXSEL_SLOT_FREE) ||
                                (tx_count_d == '0));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_irq_flag_q <= 1'b0;
    end else if (tx_event) begin
      tx_irq_flag_q <= 1'b1;
    end else if (tx_irq_clear) begin
      tx_irq_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_buffer_full_q <= 1'b0;
      tx_idle_q <= 1'b1;
    end else begin
      tx_buffer_full_q <= (tx_count_d == TX_FULL);
      tx_idle_q <= !tx_busy && !tx_load && (tx_count_d == '0);
    end
  end

  // ------------------------------------------------------------
  // receive shift register and held character
  // ------------------------------------------------------------
  logic char_valid;
  logic [DATA_W-1:0] char_data;
  logic char_parity_error;
  logic char_framing_error;
  logic held_valid_q;
  logic [WW-1:0] held_word_q;
  logic rx_push;
  logic rx_pop;
  logic ovr_event;
  logic [RCW-1:0] rx_count_q;

  utr_rx_shift #(
    .DATA_W(DATA_W),
    .OVERSAMPLE(OVERSAMPLE)
  ) u_rx (
    .clk(clk),
    .rst(rst),
    .baud_tick(baud_tick),
    .rx_line(rx_line),
    .parity_en(parity_en),
    .char_valid_q(char_valid),
    .char_data_q(char_data),
    .char_parity_error_q(char_parity_error),
    .char_framing_error_q(char_framing_error)
  );

  // the held word is the fifth place of the fifo
  assign rx_push = held_valid_q && (rx_count_q != RX_FULL) && !overrun_error_q;
  // a new stop bit while the held word is still blocked
  assign ovr_event = char_valid && held_valid_q && !rx_push && !overrun_error_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_valid_q <= 1'b0;
      held_word_q <= '0;
    end else if (overrun_error_q || ovr_event) begin
      held_valid_q <= 1'b0;
    end else if (char_valid) begin
      held_valid_q <= 1'b1;
      held_word_q <= {char_parity_error, char_framing_error, char_data};
    end else if (rx_push) begin
      held_valid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // receive buffer
  // ------------------------------------------------------------
  logic [WW-1:0] rx_mem [RX_DEPTH];
  logic [RPW-1:0] rx_wr_q;
  logic [RPW-1:0] rx_rd_q;
  logic [RCW-1:0] rx_count_d;
  logic [RCW-1:0] rx_level_after;
  logic rx_event;

  assign rx_pop = rx_read && (rx_count_q != '0);

  always_comb begin
    rx_count_d = rx_count_q;
    if (rx_push && !rx_pop) begin
      rx_count_d = rx_count_q + RCW'(1);
    end else if (rx_pop && !rx_push) begin
      rx_count_d = rx_count_q - RCW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rx_push) begin
      rx_mem[rx_wr_q] <= held_word_q;
    end
  end

  // reset is the only clear; no power-state input touches the fifo
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_wr_q <= '0;
      rx_rd_q <= '0;
      rx_count_q <= '0;
    end else begin
      if (rx_push) begin
        rx_wr_q <= (rx_wr_q == RX_PTR_LAST) ? '0 : rx_wr_q + RPW'(1);
      end
      if (rx_pop) begin
        rx_rd_q <= (rx_rd_q == RX_PTR_LAST) ? '0 : rx_rd_q + RPW'(1);
      end
      rx_count_q <= rx_count_d;
    end
  end

  // stale word stays on the outputs when an empty buffer is read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_data_q <= DATA_RST;
      parity_error_q <= 1'b0;
      framing_error_q <= 1'b0;
    end else if (rx_pop) begin
      rx_data_q <= rx_mem[rx_rd_q][DATA_W-1:0];
      parity_error_q <= rx_mem[rx_rd_q][WW-1];
      framing_error_q <= rx_mem[rx_rd_q][WW-2];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_data_available_q <= 1'b0;
    end else begin
      rx_data_available_q <= (rx_count_d != '0);
    end
  end

  // ------------------------------------------------------------
  // receive interrupt and overrun
  // ------------------------------------------------------------
  // level counted from the transfer alone, ignoring a same-cycle read
  assign rx_level_after = rx_count_q + RCW'(1);

  always_comb begin
    rx_event = 1'b0;
    unique case (rx_irq_select)
      RXSEL_EACH_A, RXSEL_EACH_B: rx_event = rx_push;
      RXSEL_THREE: rx_event = rx_push && (rx_level_after == RX_THREE);
      RXSEL_FULL: rx_event = rx_push && (rx_level_after == RX_FULL);
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_irq_flag_q <= 1'b0;
    end else if (rx_event) begin
      rx_irq_flag_q <= 1'b1;
    end else if (rx_irq_clear) begin
      rx_irq_flag_q <= 1'b0;
    end
  end

  // only software clears overrun; a new overrun wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overrun_error_q <= 1'b0;
    end else if (ovr_event) begin
      overrun_error_q <= 1'b1;
    end else if (overrun_clear) begin
      overrun_error_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // status word mirror
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= STAT_RST;
    end else begin
      status_q <= STAT_RST;
      status_q[STAT_RX_AVAIL] <= rx_data_available_q;
      status_q[STAT_OVERRUN] <= overrun_error_q;
      status_q[STAT_FRAMING] <= framing_error_q;
      status_q[STAT_PARITY] <= parity_error_q;
      status_q[STAT_RX_SEL_LO +: 2] <= rx_irq_select;
      status_q[STAT_TX_IDLE] <= tx_idle_q;
      status_q[STAT_TX_FULL] <= tx_buffer_full_q;
      status_q[STAT_TX_BREAK] <= tx_break;
      status_q[STAT_TX_SEL] <= tx_irq_select;
    end
  end
endmodule : utr_uart

// ---- sim/utr_uart_sva.sv ----
`timescale 1ns/10ps
module utr_uart_sva #(
  parameter int DATA_W = utr_pkg::DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_break,
  input wire logic tx_irq_select,
  input wire logic rx_read,
  input wire logic rx_irq_clear,
  input wire logic overrun_clear,
  input wire logic tx_line,
  input wire logic tx_buffer_full_q,
  input wire logic tx_irq_flag_q,
  input wire logic [DATA_W-1:0] rx_data_q,
  input wire logic rx_data_available_q,
  input wire logic overrun_error_q,
  input wire logic rx_irq_flag_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // transmit side
  // ------------------------------------------------------------
  sequence s_tx_load;
    $rose(tx_irq_flag_q) && !tx_break;
  endsequence
  sequence s_start_bit;
    ##[0:2] (!tx_line) [*8];
  endsequence
  property p_tx_start;
    s_tx_load |-> s_start_bit;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("tx irq without start");
  property p_tx_empty;
    $rose(tx_irq_flag_q) && $past(tx_irq_select) |-> !tx_buffer_full_q;
  endproperty
  a_tx_empty: assert property (p_tx_empty)
    else $error("tx irq with full buffer");
  property p_brk_line;
    tx_break |=> !tx_line;
  endproperty
  a_brk_line: assert property (p_brk_line)
    else $error("break line not low");
  // three cycles so a load just before break can still finish
  property p_brk_irq;
    tx_break [*3] |-> !$rose(tx_irq_flag_q);
  endproperty
  a_brk_irq: assert property (p_brk_irq)
    else $error("tx irq during break");
  // ------------------------------------------------------------
  // receive side
  // ------------------------------------------------------------
  property p_empty_read;
    rx_read && !rx_data_available_q ##1 !rx_data_available_q |-> $stable(rx_data_q);
  endproperty
  a_empty_read: assert property (p_empty_read)
    else $error("empty read changed data");
  property p_avail_fall;
    $fell(rx_data_available_q) |-> $past(rx_read);
  endproperty
  a_avail_fall: assert property (p_avail_fall)
    else $error("avail fell without read");
  property p_rx_irq;
    $rose(rx_irq_flag_q) |-> rx_data_available_q;
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("rx irq with empty buffer");
  property p_rx_sticky;
    rx_irq_flag_q && !rx_irq_clear |=> rx_irq_flag_q;
  endproperty
  a_rx_sticky: assert property (p_rx_sticky)
    else $error("rx irq dropped");
  property p_ovr_sticky;
    overrun_error_q && !overrun_clear |=> overrun_error_q;
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky)
    else $error("overrun dropped without clear");
  property p_ovr_rise;
    $rose(overrun_error_q) |-> rx_data_available_q && $past(rx_data_available_q);
  endproperty
  a_ovr_rise: assert property (p_ovr_rise)
    else $error("overrun while buffer not full");
  property p_reset;
    $fell(rst) |-> tx_line && !rx_data_available_q && !overrun_error_q;
  endproperty
  a_reset: assert property (p_reset)
    else $error("bad state after reset");
endmodule : utr_uart_sva
bind utr_uart utr_uart_sva #(.DATA_W(DATA_W)) i_sva (.clk(clk), .rst(rst),
  .tx_break(tx_break), .tx_irq_select(tx_irq_select), .rx_read(rx_read),
  .rx_irq_clear(rx_irq_clear), .overrun_clear(overrun_clear), .tx_line(tx_line),
  .tx_buffer_full_q(tx_buffer_full_q), .tx_irq_flag_q(tx_irq_flag_q), .rx_data_q(rx_data_q),
  .rx_data_available_q(rx_data_available_q), .overrun_error_q(overrun_error_q),
  .rx_irq_flag_q(rx_irq_flag_q));

// ---- sim/utr_line_model.sv ----
`timescale 1ns/10ps
module utr_line_model #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk,
  input wire logic tx_line,
  output logic rx_line
);
  logic [7:0] got[$];
  logic [7:0] sh;
  initial rx_line = 1'h1;
  // far transmitter; a low stop forces a framing fault and is cut short
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] fr;
    fr = {stop, d, 1'h0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= fr[i];
      repeat ((i < 9 || stop) ? BIT_CYC : BIT_CYC * 5 / 8) @(posedge clk);
    end
    rx_line <= 1'h1;
  endtask : send
  // far receiver; a break shows a low stop and is not kept
  always begin
    @(posedge clk);
    if (tx_line === 1'h0) begin
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        sh[i] = tx_line;
      end
      repeat (BIT_CYC) @(posedge clk);
      if (tx_line === 1'h1) got.push_back(sh);
      while (tx_line !== 1'h1) @(posedge clk);
    end
  end
endmodule : utr_line_model

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import utr_pkg::*;
  localparam int OS = 16;
  localparam int BC = 2 * OS;
  logic clk, rst, baud_tick, tx_write, tx_irq_select, tx_break, tx_irq_clear;
  logic rx_line, rx_read, rx_irq_clear, overrun_clear, tx_line, tx_idle_q, tx_irq_flag_q;
  logic parity_error_q, framing_error_q, rx_data_available_q, overrun_error_q, rx_irq_flag_q;
  logic [1:0] rx_irq_select;
  logic [DATA_W-1:0] tx_wdata, rx_data_q;
  int n_errors = 0;
  int num_checks = 0;
  utr_uart #(.OVERSAMPLE(OS)) i_dut (.clk(clk), .rst(rst), .baud_tick(baud_tick),
    .parity_en(1'h0), .tx_write(tx_write), .tx_wdata(tx_wdata),
    .tx_irq_select(tx_irq_select), .tx_break(tx_break), .tx_irq_clear(tx_irq_clear),
    .rx_line(rx_line), .rx_read(rx_read), .rx_irq_select(rx_irq_select),
    .rx_irq_clear(rx_irq_clear), .overrun_clear(overrun_clear), .tx_line(tx_line),
    .tx_buffer_full_q(), .tx_idle_q(tx_idle_q), .tx_irq_flag_q(tx_irq_flag_q),
    .rx_data_q(rx_data_q), .parity_error_q(parity_error_q),
    .framing_error_q(framing_error_q), .rx_data_available_q(rx_data_available_q),
    .overrun_error_q(overrun_error_q), .rx_irq_flag_q(rx_irq_flag_q), .status_q());
  utr_line_model #(.BIT_CYC(BC)) i_far (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));
  always #5 clk = ~clk;
  always @(posedge clk) baud_tick <= ~baud_tick;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk1(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t bit got %b exp %b", $time, g, e);
    end
  endtask : chk1
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t byte got %h exp %h", $time, g, e);
    end
  endtask : chk8
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic rd();
    rx_read <= 1'h1;
    @(posedge clk);
    rx_read <= 1'h0;
    tick(2);
  endtask : rd
  task automatic wait_rx(input int n);
    int t = 0;
    while (i_far.got.size() < n) begin
      @(posedge clk);
      t++;
      if (t > 4000) begin
        n_errors++;
        $display("[ERR] %0t no frame seen", $time);
        wrap_up();
      end
    end
  endtask : wait_rx
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_rst();
    i_far.send(8'h99, 1'h1);
    tick(4);
    chk1(rx_data_available_q, 1'h1);
    rst <= 1'h1;
    tick(2);
    rst <= 1'h0;
    tick(2);
    chk1(rx_data_available_q, 1'h0);
    chk1(tx_line, LINE_IDLE);
    chk1(tx_idle_q, 1'h1);
    $display("test reset done");
  endtask : t_rst
  task automatic t_tx(input logic sel);
    i_far.got.delete();
    tx_irq_select <= sel;
    tx_write <= 1'h1;
    tx_wdata <= 8'h5a;
    @(posedge clk);
    tx_wdata <= 8'hc3;
    @(posedge clk);
    tx_write <= 1'h0;
    tick(20);
    chk1(tx_irq_flag_q, ~sel);
    tx_irq_clear <= 1'h1;
    @(posedge clk);
    tx_irq_clear <= 1'h0;
    wait_rx(2);
    chk1(tx_irq_flag_q, 1'h1);
    chk8(i_far.got[0], 8'h5a);
    chk8(i_far.got[1], 8'hc3);
    $display("test tx select done");
  endtask : t_tx
  task automatic t_brk();
    int t = 0;
    // break cuts any frame short, so let the line go idle first
    while (tx_idle_q !== 1'h1 && t < 500) begin
      @(posedge clk);
      t++;
    end
    chk1(tx_idle_q, 1'h1);
    tx_irq_clear <= 1'h1;
    tx_break <= 1'h1;
    @(posedge clk);
    tx_irq_clear <= 1'h0;
    for (int i = 0; i < 13; i++) begin
      tick(BC);
      chk1(tx_line, LINE_BREAK);
    end
    tx_break <= 1'h0;
    tick(2 * BC);
    chk1(tx_line, LINE_IDLE);
    chk1(tx_irq_flag_q, 1'h0);
    $display("test break done");
  endtask : t_brk
  task automatic t_rxsel(input logic [1:0] sel);
    logic e;
    rx_irq_select <= sel;
    for (int k = 1; k <= 4; k++) begin
      i_far.send(8'h10 + 8'(k), 1'h1);
      tick(4);
      e = (sel < 2'h2) || (k == int'(sel) + 1);
      chk1(rx_irq_flag_q, e);
      rx_irq_clear <= 1'h1;
      @(posedge clk);
      rx_irq_clear <= 1'h0;
    end
    chk1(rx_data_available_q, 1'h1);
    for (int k = 1; k <= 4; k++) begin
      rd();
      chk8(rx_data_q, 8'h10 + 8'(k));
    end
    tick(3);
    chk1(rx_data_available_q, 1'h0);
    $display("test rx select done");
  endtask : t_rxsel
  task automatic t_ovr();
    logic [7:0] held;
    for (int k = 0; k < 6; k++) begin
      i_far.send(8'ha0 + 8'(k), 1'h1);
      tick(4);
      chk1(overrun_error_q, k == 5);
    end
    i_far.send(8'h77, 1'h1);
    tick(4);
    chk1(overrun_error_q, 1'h1);
    for (int k = 0; k < 4; k++) begin
      rd();
      chk8(rx_data_q, 8'ha0 + 8'(k));
    end
    tick(3);
    chk1(rx_data_available_q, 1'h0);
    held = rx_data_q;
    rd();
    chk8(rx_data_q, held);
    overrun_clear <= 1'h1;
    @(posedge clk);
    overrun_clear <= 1'h0;
    i_far.send(8'h3c, 1'h1);
    tick(4);
    rd();
    chk8(rx_data_q, 8'h3c);
    $display("test overrun done");
  endtask : t_ovr
  task automatic t_framing_error();
    i_far.send(8'h81, 1'h0);
    tick(BC);
    i_far.send(8'h42, 1'h1);
    tick(4);
    rd();
    chk1(framing_error_q, 1'h1);
    chk1(parity_error_q, 1'h0);
    rd();
    chk1(framing_error_q, 1'h0);
    chk8(rx_data_q, 8'h42);
    $display("test framing done");
  endtask : t_framing_error
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    {baud_tick, tx_write, tx_irq_select, tx_break, tx_irq_clear} = 5'h00;
    {rx_read, rx_irq_clear, overrun_clear, rx_irq_select} = 5'h00;
    tx_wdata = 8'h00;
    tick(2);
    rst <= 1'h0;
    @(posedge clk);
    t_rst();
    t_tx(1'h1);
    t_tx(1'h0);
    t_brk();
    for (int s = 0; s < 4; s++) t_rxsel(2'(s));
    t_ovr();
    t_framing_error();
    wrap_up();
  end
endmodule : testbench
